// ==== include/ufsb_map.svh ====
// Purpose: Register offsets, field positions, reset values for the fault status slice
// Assumes: APB with 32-bit data, word-aligned byte addresses
// Notes:   Included by bare name; definitions only
`ifndef UFSB_MAP_SVH
`define UFSB_MAP_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define UFSB_CFS_OFS      12'hD28
`define UFSB_IMASK_OFS    12'hD30
`define UFSB_ADDR_OFS     12'hD38

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define UFSB_INVSTATE_BIT 17
`define UFSB_BADOP_BIT    16
`define UFSB_ADDRV_BIT    15

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define UFSB_CFS_RST      32'h0000_0000
`define UFSB_IMASK_RST    3'h0
`define UFSB_FLAGS_RST    3'h0

`endif

// ==== include/ufsb_pkg.sv ====
// Purpose: Types shared by the fault status slice
// Assumes: Nothing beyond SystemVerilog
// Notes:   Constants live in ufsb_map.svh
package ufsb_pkg;
  // Index of each sticky flag inside the three-bit slice
  typedef enum logic [1:0] {
    UFSB_FLAG_ADDRV = 2'h0,
    UFSB_FLAG_BADOP = 2'h1,
    UFSB_FLAG_INV   = 2'h2
  } ufsb_flag_e;

  typedef logic [2:0] ufsb_flags_t;
endpackage

// ==== rtl/ufsb_fault_status.sv ====
// Purpose: Sticky usage/bus fault flags (bits 17:15) with APB access
// Assumes: Core decode gives one-cycle event pulses on mclk_i
// Notes:   Set wins over a same-cycle write-one clear
`timescale 1ns/1ps
`default_nettype none
`include "ufsb_map.svh"

module ufsb_fault_status
  import ufsb_pkg::*;
(
  input  wire logic        mclk_i,          // Core clock, 25 MHz
  input  wire logic        arst_n_i,        // Async reset, active low
  // APB slave
  input  wire logic        psel,            // Select
  input  wire logic        penable,         // Access phase
  input  wire logic        pwrite,          // Write when high
  input  wire logic [11:0] paddr,           // Byte address
  input  wire logic [31:0] pwdata,          // Write data
  input  wire logic [3:0]  pstrb,           // Byte lane strobes
  output logic      [31:0] prdata,          // Read data
  output logic             pready,          // Transfer done
  output logic             pslverr,         // Unmapped address
  // Core fault events
  input  wire logic        status_fault_i,  // Illegal execution_status_reg use
  input  wire logic        undecodable_i,   // Decoder could not decode
  input  wire logic [31:0] instr_pc_i,      // PC of instruction in decode
  input  wire logic        bus_fault_i,     // Bus fault occurred
  input  wire logic        bus_addr_known_i,// Bus fault address is known
  input  wire logic [31:0] bus_addr_i,      // Faulting bus address
  input  wire logic        mem_fault_i,     // Later memory management fault
  // Outputs to core
  output logic [31:0]      stacked_pc_o,    // Return PC for usage fault
  output logic             usage_fault_o,   // One-cycle usage fault pulse
  output logic [31:0]      bus_fault_address_reg_o, // Captured fault address
  output logic             invalid_state_flag_o,
  output logic             bad_opcode_flag_o,
  output logic             bus_fault_addr_valid_o,
  output logic             irq_o            // Level interrupt
);

  // ----------------------------------------------------------------
  // Decode helpers
  // ----------------------------------------------------------------
  // Word match on the register index; lanes chosen by pstrb
  function automatic logic hit(input logic [11:0] a, input logic [11:0] ofs);
    hit = (a[11:2] == ofs[11:2]);
  endfunction

  ufsb_flags_t flags_reg;       // {inv, badop, addrv}
  logic [2:0]  imask_reg;       // Interrupt mask, same layout
  logic        wr_acc;          // Write completes this cycle
  logic        rd_acc;          // Read completes this cycle
  logic        inv_set;         // Qualified invalid-state event
  logic        addrv_set;       // Qualified address-valid event
  ufsb_flags_t w1c;             // Write-one clear bits
  ufsb_flags_t set_v;           // Hardware set bits
  logic        mapped;          // Address decodes to a register
  logic [31:0] cfs_view;        // Full status word view

  assign wr_acc  = psel & penable & pwrite;
  assign rd_acc  = psel & penable & ~pwrite;
  assign mapped  = hit(paddr, `UFSB_CFS_OFS) | hit(paddr, `UFSB_IMASK_OFS)
                 | hit(paddr, `UFSB_ADDR_OFS);

  // ----------------------------------------------------------------
  // Event qualification
  // ----------------------------------------------------------------
  // Undefined opcodes outrank status misuse
  assign inv_set   = status_fault_i & ~undecodable_i;
  assign addrv_set = bus_fault_i & bus_addr_known_i;
  assign set_v     = {inv_set, undecodable_i, addrv_set};

  // Flag bits 17:15 sit in lanes 2 and 1; byte/halfword use strobes
  always_comb
  begin
    w1c = '0;
    if (wr_acc && hit(paddr, `UFSB_CFS_OFS))
    begin
      w1c[2] = pstrb[2] & pwdata[`UFSB_INVSTATE_BIT];
      w1c[1] = pstrb[2] & pwdata[`UFSB_BADOP_BIT];
      w1c[0] = pstrb[1] & pwdata[`UFSB_ADDRV_BIT];
    end
  end

  // ----------------------------------------------------------------
  // Sticky flags
  // ----------------------------------------------------------------
  // Set beats clear so an event in the clearing cycle survives
  always_ff @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      flags_reg <= `UFSB_FLAGS_RST;
    else
    begin
      flags_reg[2:1] <= (flags_reg[2:1] & ~w1c[2:1]) | set_v[2:1];
      if (set_v[0])
        flags_reg[0] <= 1'b1;
      else if (mem_fault_i)
        flags_reg[0] <= 1'b0;
      else if (w1c[0])
        flags_reg[0] <= 1'b0;
    end
  end

  // Fault address captured only with a known address
  always_ff @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      bus_fault_address_reg_o <= 32'h0000_0000;
    else if (addrv_set)
      bus_fault_address_reg_o <= bus_addr_i;
  end

  // Return PC is the faulting instruction itself, not the next one
  always_ff @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      stacked_pc_o  <= 32'h0000_0000;
      usage_fault_o <= 1'b0;
    end
    else
    begin
      usage_fault_o <= inv_set | undecodable_i;
      if (inv_set | undecodable_i)
        stacked_pc_o <= instr_pc_i;
    end
  end

  // ----------------------------------------------------------------
  // Mask register and interrupt
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      imask_reg <= `UFSB_IMASK_RST;
    else if (wr_acc && hit(paddr, `UFSB_IMASK_OFS))
    begin
      if (pstrb[2])
        imask_reg[2:1] <= pwdata[17:16];
      if (pstrb[1])
        imask_reg[0] <= pwdata[15];
    end
  end

  // Registered so the output comes from a flip-flop; one cycle of lag
  always_ff @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      irq_o <= 1'b0;
    else
      irq_o <= |(flags_reg & imask_reg);
  end

  // Mirror flags for the core
  always_ff @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      invalid_state_flag_o   <= 1'b0;
      bad_opcode_flag_o      <= 1'b0;
      bus_fault_addr_valid_o <= 1'b0;
    end
    else
    begin
      invalid_state_flag_o   <= flags_reg[2];
      bad_opcode_flag_o      <= flags_reg[1];
      bus_fault_addr_valid_o <= flags_reg[0];
    end
  end

  // ----------------------------------------------------------------
  // APB read path
  // ----------------------------------------------------------------
  // Reserved bits 14:13 and all others outside the slice read zero
  always_comb
  begin
    cfs_view = 32'h0000_0000;
    cfs_view[`UFSB_INVSTATE_BIT] = flags_reg[2];
    cfs_view[`UFSB_BADOP_BIT]    = flags_reg[1];
    cfs_view[`UFSB_ADDRV_BIT]    = flags_reg[0];
  end

  // Zero-wait answer: pready rises in the setup cycle's following edge
  always_ff @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & ~mapped;
      if (psel && !penable && !pwrite)
      begin
        if (hit(paddr, `UFSB_CFS_OFS))
          prdata <= cfs_view;
        else if (hit(paddr, `UFSB_IMASK_OFS))
          prdata <= {14'h0000, imask_reg, 15'h0000};
        else if (hit(paddr, `UFSB_ADDR_OFS))
          prdata <= bus_fault_address_reg_o;
        else
          prdata <= 32'h0000_0000;
      end
    end
  end

endmodule
`default_nettype wire

// ==== sim/ufsb_monitor.sv ====
// Purpose: Port assertions for the fault status slice
// Assumes: Flag outputs lag their cause by one or two edges
// Notes:   Bound below to every instance of the slice
`timescale 1ns/1ps
`default_nettype none
module ufsb_monitor (
  input wire logic        mclk_i,
  input wire logic        arst_n_i,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        status_fault_i,
  input wire logic        undecodable_i,
  input wire logic [31:0] instr_pc_i,
  input wire logic        bus_fault_i,
  input wire logic        bus_addr_known_i,
  input wire logic        mem_fault_i,
  input wire logic [31:0] stacked_pc_o,
  input wire logic        usage_fault_o,
  input wire logic        invalid_state_flag_o,
  input wire logic        bad_opcode_flag_o,
  input wire logic        bus_fault_addr_valid_o
);
  // ----------------------------------------------------------------
  // Checks, all on the core clock
  // ----------------------------------------------------------------
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!arst_n_i);
  a_inv_set: assert property (
    status_fault_i && !undecodable_i |-> ##[1:2] invalid_state_flag_o) else $error("inv not set");
  a_inv_cause: assert property (
    $rose(invalid_state_flag_o) |-> $past(status_fault_i, 2) && !$past(undecodable_i, 2))
    else $error("inv set without cause");
  a_bad_opcode_flag_set: assert property (
    undecodable_i |-> ##[1:2] bad_opcode_flag_o) else $error("bad opcode not set");
  a_pc_stack: assert property (
    usage_fault_o |-> stacked_pc_o == $past(instr_pc_i)) else $error("stacked pc wrong");
  a_addrv_set: assert property (
    bus_fault_i && bus_addr_known_i |-> ##[1:2] bus_fault_addr_valid_o) else $error("addrv unset");
  a_mem_clear: assert property (
    mem_fault_i && !bus_fault_i |-> ##[1:2] !bus_fault_addr_valid_o) else $error("addrv kept");
  a_w1c_only: assert property (
    $fell(invalid_state_flag_o) |-> $past(pready, 2) && $past(pwrite, 2) && $past(pwdata[17], 2))
    else $error("inv cleared without write");
  a_rsvd_zero: assert property (
    pready && !pwrite && paddr == 12'hD28 |-> prdata[14:13] == 2'h0) else $error("rsvd set");
  a_ready_one: assert property (
    psel && !penable |=> pready ##1 !pready) else $error("pready timing");
  cover property (usage_fault_o);
  cover property ($fell(bus_fault_addr_valid_o));
  cover property (pready && pwrite);
endmodule
bind ufsb_fault_status ufsb_monitor mon (.*);
`default_nettype wire

// ==== sim/ufsb_core_model.sv ====
// Purpose: Core-side event source for the fault status slice
// Assumes: Each event lasts one clock
// Notes:   Address inverted after an event so stale values never match
`timescale 1ns/1ps
`default_nettype none
module ufsb_core_model (
  input  wire logic        mclk_i,
  output var  logic [4:0]  evt_o,  // Status, undecodable, bus, known, mem
  output var  logic [31:0] pc_o    // Instruction PC or faulting address
);
  initial
  begin
    evt_o = 5'h00;
    pc_o  = 32'h0000_0000;
  end
  // One event pulse, PC held with it
  task automatic fire(input logic [4:0] ev, input logic [31:0] pc);
    @(posedge mclk_i);
    evt_o <= ev;
    pc_o  <= pc;
    @(posedge mclk_i);
    evt_o <= 5'h00;
    pc_o  <= ~pc;
    @(posedge mclk_i);
  endtask
endmodule
`default_nettype wire

// ==== sim/usage_bus_fault_status_bits_bench.sv ====
// Purpose: Register-level tests of the fault status slice
// Assumes: Zero-wait APB slave
// Notes:   Events come from the core model
`timescale 1ns/1ps
`default_nettype none
module usage_bus_fault_status_bits_bench;
  logic        mclk_i, arst_n_i, psel, penable, pwrite, pready, pslverr, err;
  logic        usage_fault_o, invalid_state_flag_o, bad_opcode_flag_o;
  logic        bus_fault_addr_valid_o, irq_o;
  logic [11:0] paddr;
  logic [3:0]  pstrb;
  logic [4:0]  evt;
  logic [31:0] pwdata, prdata, rd, pc, stacked_pc_o, bus_fault_address_reg_o;
  int          failures, checks, cyc;
  ufsb_core_model core (.mclk_i(mclk_i), .evt_o(evt), .pc_o(pc));
  ufsb_fault_status uut (.*, .status_fault_i(evt[4]), .undecodable_i(evt[3]),
    .bus_fault_i(evt[2]), .bus_addr_known_i(evt[1]), .mem_fault_i(evt[0]),
    .instr_pc_i(pc), .bus_addr_i(pc));
  initial
  begin
    mclk_i = 1'b0;
    forever #20 mclk_i = ~mclk_i;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // One APB transfer; holds the request until pready is sampled
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     input logic [3:0] s);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge mclk_i);
    penable <= 1'b1;
    do @(posedge mclk_i); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk_i);
  endtask
  task automatic rchk(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0, 4'h0);
    chk(rd, exp);
  endtask
  task automatic summarize;
    $display("checks=%0d failures=%0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // Hang guard
  always @(posedge mclk_i)
  begin
    cyc++;
    if (cyc == 2000)
    begin
      failures++;
      summarize();
    end
  end
  initial
  begin
    {arst_n_i, psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
    repeat (6) @(posedge mclk_i);
    arst_n_i <= 1'b1;
    @(posedge mclk_i);
    rchk(12'hD28, 32'h0);
    rchk(12'hD3C, 32'h0);
    chk({31'h0, err}, 32'h1);
    apb(1'b1, 12'hD30, 32'h0003_8000, 4'hF);
    rchk(12'hD30, 32'h0003_8000);
    $display("test reset_map done");
    core.fire(5'h10, 32'h100);
    rchk(12'hD28, 32'h0002_0000);
    chk(stacked_pc_o, 32'h100);
    chk({31'h0, irq_o}, 32'h1);
    chk({31'h0, invalid_state_flag_o}, 32'h1);
    apb(1'b1, 12'hD28, 32'h0, 4'hF);
    rchk(12'hD28, 32'h0002_0000);
    apb(1'b1, 12'hD28, 32'h0002_0000, 4'h4);
    rchk(12'hD28, 32'h0);
    $display("test invalid_state done");
    core.fire(5'h18, 32'h200);
    rchk(12'hD28, 32'h0001_0000);
    chk(stacked_pc_o, 32'h200);
    chk({31'h0, bad_opcode_flag_o}, 32'h1);
    chk({31'h0, invalid_state_flag_o}, 32'h0);
    $display("test bad_opcode done");
    core.fire(5'h06, 32'hABC);
    rchk(12'hD28, 32'h0001_8000);
    rchk(12'hD38, 32'hABC);
    chk(bus_fault_address_reg_o, 32'hABC);
    chk({31'h0, bus_fault_addr_valid_o}, 32'h1);
    core.fire(5'h01, 32'h0);
    rchk(12'hD28, 32'h0001_0000);
    chk({31'h0, bus_fault_addr_valid_o}, 32'h0);
    core.fire(5'h06, 32'h44);
    apb(1'b1, 12'hD28, 32'h0000_8000, 4'h2);
    rchk(12'hD28, 32'h0001_0000);
    apb(1'b1, 12'hD30, 32'h0, 4'hF);
    @(posedge mclk_i);
    chk({31'h0, irq_o}, 32'h0);
    $display("test addr_valid done");
    summarize();
  end
endmodule
`default_nettype wire
